// file: dtc_pkg.sv
/*
  Package for the decimation timestamp counter block: register map,
  field layouts, reset values and filter grade encodings.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package dtc_pkg;

  localparam int DF_W  = 8;
  localparam int NV_W  = 6;

  // Byte offsets
  localparam logic [7:0] MAIN_CFG_OFS = 8'h00;
  localparam logic [7:0] AUX_CFG_OFS  = 8'h04;
  localparam logic [7:0] TSTAMP_OFS   = 8'h08;
  localparam logic [7:0] CTRL_OFS     = 8'h0C;
  localparam logic [7:0] ELAPSED_OFS  = 8'h10;

  // Filter config fields
  localparam int CFG_DF_LSB    = 0;
  localparam int CFG_GRADE_LSB = 8;
  localparam int CFG_EN_BIT    = 12;

  // Timestamp fields
  localparam int TS_CNT_LSB = 0;
  localparam int TS_NV_LSB  = 16;

  // Control fields
  localparam int CTRL_NVCLR_BIT = 0;

  localparam logic [DF_W-1:0]  DF_RST    = 8'h0F;
  localparam logic [1:0]       GRADE_RST = 2'h1;
  localparam logic [31:0]      RDATA_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    DTC_GRADE_OFF  = 2'b00,
    DTC_GRADE_SECOND = 2'b01,
    DTC_GRADE_THIRD  = 2'b10,
    DTC_GRADE_FAST = 2'b11
  } dtc_grade_e;

endpackage

// file: dtc_down_counter.sv
/*
  Decimation down-counter with new-value counter.
  Assumes tick is a one-cycle enable from the modulator path.
*/
`timescale 1ns/10ps
`default_nettype none
module dtc_down_counter
  import dtc_pkg::*;
#(
  parameter int DW = DF_W,
  parameter int NW = NV_W
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          enable,
  input  wire logic          tick,
  input  wire logic          nv_clear,
  input  wire logic [DW-1:0] factor,
  output logic      [DW-1:0] count,
  output logic      [NW-1:0] nv_count,
  output logic               result_pulse
);

  logic [DW-1:0] count_reg;
  logic [NW-1:0] nv_reg;
  logic          res_reg;
  wire           underflow = enable && tick && (count_reg == '0);
  wire  [DW-1:0] count_next = !enable   ? factor :
                              underflow ? factor :
                              tick      ? count_reg - 1'b1 :
                                          count_reg;
  // Increment lands in the same step as the reload, not one tick late
  wire  [NW-1:0] nv_next = underflow ? nv_reg + 1'b1 :
                           nv_clear  ? '0 : nv_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= DF_RST;
      nv_reg    <= '0;
      res_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      nv_reg    <= nv_next;
      res_reg   <= underflow;
    end
  end

  assign count        = count_reg;
  assign nv_count     = nv_reg;
  assign result_pulse = res_reg;

endmodule
`default_nettype wire

// file: dtc_top.sv
/*
  Decimation filter timestamp block: APB registers for main and aux
  filter configuration, timestamp readout and computed elapsed elapsed_a.
  Assumes mod_tick is synchronous to core_clk, one cycle per modulator tick.
*/
// The APB register port and the register addresses were chosen for this implementation.
// What this block does
// - Grade codes 01 second, 10 third, 11 fast
// - Oversampling rate is factor field plus one
// - Timestamp shows new-value and down-counter fields
// - Elapsed = nv*(factor+1) + factor - count
// - Underflow increments new-value counter same step
// - Underflow reloads down-counter from factor
// - Increment coincides with reload, never late
`timescale 1ns/10ps
`default_nettype none
module dtc_top
  import dtc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mod_tick,
  output logic             main_result_pulse,
  output logic             aux_result_pulse,
  output logic      [8:0]  main_osr,
  output logic      [8:0]  aux_osr,
  output logic      [1:0]  main_grade_out,
  output logic      [1:0]  aux_grade_out
);

  function automatic logic [8:0] osr_of(input logic [DF_W-1:0] df);
    osr_of = {1'b0, df} + 9'h001;
  endfunction

  logic [DF_W-1:0] main_decimation_factor_reg;
  logic [DF_W-1:0] aux_decimation_factor_reg;
  logic [1:0]      main_filter_grade_reg;
  logic [1:0]      aux_filter_grade_reg;
  logic            main_en_reg;
  logic            aux_en_reg;
  logic [31:0]     prdata_reg;
  logic            nv_clear_pulse;

  logic [DF_W-1:0] decimation_down_counter;
  logic [NV_W-1:0] new_value_counter;

  wire setup      = psel && !penable;
  wire wr_access  = psel && penable && pwrite;
  wire hit_main   = (paddr == MAIN_CFG_OFS);
  wire hit_aux    = (paddr == AUX_CFG_OFS);
  wire hit_ts     = (paddr == TSTAMP_OFS);
  wire hit_ctrl   = (paddr == CTRL_OFS);
  wire hit_el     = (paddr == ELAPSED_OFS);
  wire hit_any    = hit_main || hit_aux || hit_ts || hit_ctrl || hit_el;

  // Low byte lane carries the factor, second lane grade and enable
  wire wr_main = wr_access && hit_main;
  wire wr_aux  = wr_access && hit_aux;

  wire [31:0] main_cfg_word = {19'h0_0000, main_en_reg, 2'b00,
                               main_filter_grade_reg, main_decimation_factor_reg};
  wire [31:0] aux_cfg_word  = {19'h0_0000, aux_en_reg, 2'b00,
                               aux_filter_grade_reg, aux_decimation_factor_reg};
  // Timestamp snapshot is one word so count and nv are always coherent
  wire [31:0] timestamp_register = {{(16-NV_W){1'b0}}, new_value_counter,
                                    {(16-DF_W){1'b0}}, decimation_down_counter};

  // Elapsed elapsed_a computed in hardware for convenience
  wire [31:0] elapsed_a = 32'(new_value_counter) * 32'(osr_of(main_decimation_factor_reg))
                        + 32'(main_decimation_factor_reg)
                        - 32'(decimation_down_counter);

  wire [31:0] rd_mux = hit_main ? main_cfg_word :
                       hit_aux  ? aux_cfg_word :
                       hit_ts   ? timestamp_register :
                       hit_el   ? elapsed_a :
                                  RDATA_UNMAPPED;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_decimation_factor_reg <= DF_RST;
      main_filter_grade_reg      <= GRADE_RST;
      main_en_reg                <= 1'b0;
    end else if (wr_main) begin
      if (pstrb[0]) begin
        main_decimation_factor_reg <= pwdata[CFG_DF_LSB +: DF_W];
      end
      if (pstrb[1]) begin
        main_filter_grade_reg <= pwdata[CFG_GRADE_LSB +: 2];
        main_en_reg           <= pwdata[CFG_EN_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_decimation_factor_reg <= DF_RST;
      aux_filter_grade_reg      <= GRADE_RST;
      aux_en_reg                <= 1'b0;
    end else if (wr_aux) begin
      if (pstrb[0]) begin
        aux_decimation_factor_reg <= pwdata[CFG_DF_LSB +: DF_W];
      end
      if (pstrb[1]) begin
        aux_filter_grade_reg <= pwdata[CFG_GRADE_LSB +: 2];
        aux_en_reg           <= pwdata[CFG_EN_BIT];
      end
    end
  end

  // Read data captured in setup so the access phase is zero-wait
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  assign nv_clear_pulse = wr_access && hit_ctrl && pstrb[0] && pwdata[CTRL_NVCLR_BIT];

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // Overflowing rate combinations are the software's to avoid; no guard here
  assign main_osr       = osr_of(main_decimation_factor_reg);
  assign aux_osr        = osr_of(aux_decimation_factor_reg);
  assign main_grade_out = main_filter_grade_reg;
  assign aux_grade_out  = aux_filter_grade_reg;

  dtc_down_counter #(.DW(DF_W), .NW(NV_W)) u_main_cnt (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .enable       (main_en_reg),
    .tick         (mod_tick),
    .nv_clear     (nv_clear_pulse),
    .factor       (main_decimation_factor_reg),
    .count        (decimation_down_counter),
    .nv_count     (new_value_counter),
    .result_pulse (main_result_pulse)
  );

  dtc_down_counter #(.DW(DF_W), .NW(NV_W)) u_aux_cnt (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .enable       (aux_en_reg),
    .tick         (mod_tick),
    .nv_clear     (1'b0),
    .factor       (aux_decimation_factor_reg),
    .count        (),
    .nv_count     (),
    .result_pulse (aux_result_pulse)
  );

endmodule
`default_nettype wire

// file: dtc_top_properties.sv
/* Port checker for dtc_top.
   Assumes a bind to dtc_top and zero-wait APB. */
`timescale 1ns/10ps
`default_nettype none
module dtc_top_properties
  import dtc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        mod_tick,
  input wire logic        main_result_pulse,
  input wire logic        aux_result_pulse,
  input wire logic [8:0]  main_osr,
  input wire logic [8:0]  aux_osr,
  input wire logic [1:0]  main_grade_out,
  input wire logic [1:0]  aux_grade_out
);
  wire logic wr = psel && penable && pwrite;
  wire logic mapped = paddr inside {MAIN_CFG_OFS, AUX_CFG_OFS, TSTAMP_OFS, CTRL_OFS, ELAPSED_OFS};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_main_grade: assert property (wr && paddr == MAIN_CFG_OFS && pstrb[1]
    |=> main_grade_out == $past(pwdata[9:8])) else $error("main grade wrong");
  a_aux_grade: assert property (wr && paddr == AUX_CFG_OFS && pstrb[1]
    |=> aux_grade_out == $past(pwdata[9:8])) else $error("aux grade wrong");
  a_main_rate: assert property (wr && paddr == MAIN_CFG_OFS && pstrb[0]
    |=> main_osr == $past(pwdata[7:0]) + 9'h001) else $error("main rate wrong");
  a_aux_rate: assert property (wr && paddr == AUX_CFG_OFS && pstrb[0]
    |=> aux_osr == $past(pwdata[7:0]) + 9'h001) else $error("aux rate wrong");
  a_reset_rate: assert property ($rose(rst_n)
    |-> main_osr == 9'h010 && aux_grade_out == GRADE_RST) else $error("reset rate wrong");
  a_err_unmapped: assert property (psel && penable
    |-> pslverr == !mapped) else $error("slave error wrong");
  a_zero_unmapped: assert property (psel && !penable && !pwrite && !mapped
    |=> prdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_main_cause: assert property (main_result_pulse
    |-> $past(mod_tick)) else $error("main pulse without tick");
  a_aux_cause: assert property (aux_result_pulse
    |-> $past(mod_tick)) else $error("aux pulse without tick");
endmodule
bind dtc_top dtc_top_properties u_props (.core_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pslverr, .mod_tick, .main_result_pulse,
  .aux_result_pulse, .main_osr, .aux_osr, .main_grade_out, .aux_grade_out);
`default_nettype wire

// file: dtc_top_bench.sv
/* Self-checking bench for dtc_top over APB and the tick input.
   Assumes pready answers within the watchdog span. */
`timescale 1ns/10ps
`default_nettype none
module dtc_top_bench
  import dtc_pkg::*;
();
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, mod_tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [8:0]  main_osr, aux_osr;
  logic [1:0]  main_grade_out, aux_grade_out;
  logic        main_result_pulse, aux_result_pulse;
  logic [15:0] r;
  logic [31:0] exp_q[$];
  int          fail_count, n_tests;
  int          main_pulses, aux_pulses;
  dtc_top dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .mod_tick, .main_result_pulse, .aux_result_pulse,
    .main_osr, .aux_osr, .main_grade_out, .aux_grade_out);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Reads queue their expectation; an idle cycle follows so psel never toggles twice
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (!pready) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    if (psel && penable && !pwrite && pready) check(prdata, exp_q.pop_front());
  end
  always @(posedge core_clk) begin
    if (main_result_pulse) main_pulses++;
    if (aux_result_pulse) aux_pulses++;
  end
  task automatic tick;
    mod_tick <= 1'b1;
    @(posedge core_clk);
    mod_tick <= 1'b0;
    @(posedge core_clk);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    conclude;
  end
  initial begin
    {rst_n, psel, penable, pwrite, mod_tick} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    r = 16'h7600;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    xfer(1'b0, MAIN_CFG_OFS, 32'h0000_010F);
    xfer(1'b0, TSTAMP_OFS, 32'h0000_000F);
    check(32'(main_osr), 32'h0000_0010);
    $display("reset values done");
    for (int i = 1; i < 4; i++) begin
      r = lfsr(r);
      xfer(1'b1, MAIN_CFG_OFS, (32'(i) << 8) | 32'h0000_0004);
      // Aux rates stay at 16 or below, clear of every overflow rate
      xfer(1'b1, AUX_CFG_OFS, (32'(i) << 8) | 32'(r[3:0]));
      check(32'(main_grade_out), 32'(i));
      check(32'(aux_grade_out), 32'(i));
      check(32'(main_osr), 32'h0000_0005);
      check(32'(aux_osr), 32'(r[3:0]) + 1);
    end
    $display("grade and rate done");
    // Aux factor first, enable after, so the count starts from the new factor
    xfer(1'b1, AUX_CFG_OFS, 32'h0000_0102);
    xfer(1'b1, AUX_CFG_OFS, 32'h0000_1102);
    check(32'(aux_osr), 32'h0000_0003);
    xfer(1'b1, MAIN_CFG_OFS, 32'h0000_1304);
    xfer(1'b1, TSTAMP_OFS, {r, r});
    for (int t = 0; t < 12; t++) begin
      xfer(1'b0, TSTAMP_OFS, 32'((t / 5) << 16 | (4 - t % 5)));
      xfer(1'b0, ELAPSED_OFS, 32'(t));
      tick;
    end
    mod_tick <= 1'b1;
    repeat (5) @(posedge core_clk);
    mod_tick <= 1'b0;
    @(posedge core_clk);
    xfer(1'b0, TSTAMP_OFS, 32'h0003_0002);
    xfer(1'b0, ELAPSED_OFS, 32'h0000_0011);
    xfer(1'b1, CTRL_OFS, 32'h0000_0001);
    xfer(1'b0, TSTAMP_OFS, 32'h0000_0002);
    xfer(1'b1, 8'h14, {r, r});
    xfer(1'b0, 8'h14, 32'h0000_0000);
    tick;
    tick;
    tick;
    // Software reread loop, bounded only by the watchdog
    xfer(1'b0, TSTAMP_OFS, 32'h0001_0004);
    while (prdata[7:0] == 8'h04) begin
      tick;
      xfer(1'b0, TSTAMP_OFS, 32'h0001_0003);
    end
    xfer(1'b0, ELAPSED_OFS, 32'h0000_0006);
    check(32'(main_pulses), 32'h0000_0004);
    check(32'(aux_pulses), 32'h0000_0007);
    $display("counter and map done");
    conclude;
  end
endmodule
`default_nettype wire
